/* hdl/ubr_consts.vh */
// Constants for the break-reset UART block: APB map, fields, timing.
// Assumes a 100 MHz ref_clk; included by the design files by bare name.
// Function
// RQ1: Baud 1200 to 4M, parity, 1-2 stops; 16-bit divisor reaches down to only about 1526 baud
// RQ2: RTS/CTS flow control on out of reset
// RQ3: Board ties CTS low to disable flow
// RQ4: Break is receive line held low
// RQ5: Break longer than timeout resets device
// RQ6: Timeout below 1000 zero, clamp 255000
// RQ7: Timeout defaults zero, zero disables
// RQ8: Device can drive break on transmit
// RQ9: UART outputs high-impedance while in reset
// RQ10: Other devices release bus after reset
// RQ11: After reset host lines reach own UART
// RQ12: Bypass command routes host to pins, sleep
// RQ13: Only physical reset leaves bypass mode
// RQ14: Host closes radio links before bypass
// RQ15: UART break is one reset source
// RQ16: Inputs pulled down, RTS pulled up in reset; only RX has a pull-down here, CTS has none
// RQ17: Break count restarts on high, microsecond base
// RQ18: Start, 8 data LSB first, parity, stops
`ifndef UBR_CONSTS_VH
`define UBR_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define UBR_OFF_CTRL 12'h000
`define UBR_OFF_DIV 12'h004
`define UBR_OFF_TMO 12'h008
`define UBR_OFF_TXD 12'h00C
`define UBR_OFF_RXD 12'h010
`define UBR_OFF_STAT 12'h014
`define UBR_OFF_IRQS 12'h018
`define UBR_OFF_IRQM 12'h01C

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define UBR_CTRL_PAR_EN 0
`define UBR_CTRL_PAR_ODD 1
`define UBR_CTRL_TWO_STOP 2
`define UBR_CTRL_FLOW 3
`define UBR_CTRL_TXBRK 4
`define UBR_CTRL_BYPASS 5
`define UBR_CTRL_RST 6'h08

// ------------------------------------------------------------
// Baud divisor: ref_clk cycles per bit, 16 bits reaches down to about 1526 baud
// ------------------------------------------------------------
`define UBR_DIV_W 16
`define UBR_DIV_RST 16'h0364
`define UBR_DIV_MIN 16'h0019

// ------------------------------------------------------------
// Break timeout in microseconds
// ------------------------------------------------------------
`define UBR_TMO_W 18
`define UBR_TMO_MIN_US 18'd1000
`define UBR_TMO_MAX_US 18'd255000
`define UBR_TMO_RST 18'h00000
`define UBR_CLK_MHZ 100
`define UBR_US_CYC (`UBR_CLK_MHZ * 1)

// ------------------------------------------------------------
// Interrupt bits
// ------------------------------------------------------------
`define UBR_IRQ_RXDONE 0
`define UBR_IRQ_TXDONE 1
`define UBR_IRQ_PARERR 2
`define UBR_IRQ_FRMERR 3
`define UBR_IRQ_BREAK 4
`define UBR_IRQ_W 5

`endif

/* hdl/ubr_bit_timer.v */
// Bit-period timer: pulses at mid-bit or end-of-bit of a serial frame.
// Assumes restart is a one-cycle pulse at the edge of the start bit.
`timescale 1ns/1ps
`include "ubr_consts.vh"
module ubr_bit_timer (
  input wire ref_clk,
  input wire sys_rst,
  input wire restart,
  input wire half,
  input wire [`UBR_DIV_W-1:0] divisor,
  output reg tick
);
  reg [`UBR_DIV_W-1:0] cnt_q;

  // -----------------------------
  // Counter, reloaded at each tick
  // -----------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= {`UBR_DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (restart) begin
      // First period half long so receive samples mid-bit
      cnt_q <= half ? {1'b0, divisor[`UBR_DIV_W-1:1]} : divisor;
      tick <= 1'b0;
    end else if (cnt_q <= 16'h0001) begin
      cnt_q <= divisor;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

/* hdl/ubr_uart.v */
// UART with break-triggered reset, bypass routing and APB registers.
// Assumes APB master on ref_clk; pins are synchronous to ref_clk.
`timescale 1ns/1ps
`include "ubr_consts.vh"
module ubr_uart (
  input wire ref_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxIn,
  input wire clear_to_send_in_n,
  output reg txOut,
  output reg txOe,
  output reg request_to_send_out_n,
  output reg rtsOe,
  output reg rxPullDown,
  output reg rtsPullUp,
  input wire hostTxIn,
  input wire hostRtsInN,
  output reg hostRxOut,
  output reg hostCtsOutN,
  output reg bypassTxOut,
  output reg bypassRtsOutN,
  output reg deepSleep,
  output reg breakResetReq,
  output reg irq
);
  localparam TX_IDLE = 2'b00;
  localparam TX_SHIFT = 2'b01;
  localparam RX_IDLE = 2'b00;
  localparam RX_SHIFT = 2'b01;

  reg [5:0] ctrl_q;
  reg [`UBR_DIV_W-1:0] div_q;
  reg [`UBR_TMO_W-1:0] tmo_q;
  reg [`UBR_IRQ_W-1:0] irqs_q;
  reg [`UBR_IRQ_W-1:0] irqm_q;
  reg bypass_q;
  reg [7:0] txData_q;
  reg txPend_q;
  reg [1:0] txState_q;
  reg [10:0] txShift_q;
  reg [3:0] txLeft_q;
  reg [1:0] rxState_q;
  reg [9:0] rxShift_q;
  reg [3:0] rxLeft_q;
  reg [7:0] rxData_q;
  reg rxFull_q;
  reg [6:0] usCnt_q;
  reg [`UBR_TMO_W-1:0] brkUs_q;
  reg brkSeen_q;
  reg [`UBR_IRQ_W-1:0] evt;
  reg [`UBR_TMO_W-1:0] tmoEff;
  wire txTick;
  wire rxTick;
  wire wrEn = psel && penable && pwrite;
  wire rdEn = psel && penable && !pwrite;
  wire txStart = (txState_q == TX_IDLE) && txPend_q &&
    (!ctrl_q[`UBR_CTRL_FLOW] || !clear_to_send_in_n);
  wire rxStart = (rxState_q == RX_IDLE) && !rxIn && !brkSeen_q;
  wire parity = ^txData_q ^ ctrl_q[`UBR_CTRL_PAR_ODD];
  wire rxPar = ^rxShift_q[8:1] ^ ctrl_q[`UBR_CTRL_PAR_ODD];

  // -----------------------------
  // Bit timers for both directions
  // -----------------------------
  ubr_bit_timer txTimer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .restart(txStart),
    .half(1'b0),
    .divisor(div_q),
    .tick(txTick)
  );
  ubr_bit_timer rxTimer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .restart(rxStart),
    .half(1'b1),
    .divisor(div_q),
    .tick(rxTick)
  );

  // -----------------------------
  // Effective break timeout
  // -----------------------------
  always @* begin
    if (tmo_q < `UBR_TMO_MIN_US) begin
      tmoEff = `UBR_TMO_RST; // [RQ6]
    end else if (tmo_q > `UBR_TMO_MAX_US) begin
      tmoEff = `UBR_TMO_MAX_US; // [RQ6]
    end else begin
      tmoEff = tmo_q;
    end
  end

  // -----------------------------
  // APB registers and sticky status
  // -----------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `UBR_CTRL_RST; // [RQ2] flow control on
      div_q <= `UBR_DIV_RST;
      tmo_q <= `UBR_TMO_RST; // [RQ7]
      irqm_q <= {`UBR_IRQ_W{1'b0}};
      irqs_q <= {`UBR_IRQ_W{1'b0}};
      bypass_q <= 1'b0; // [RQ11]
      txData_q <= 8'h00;
      txPend_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      // Set wins over a write-one clear in the same cycle
      irqs_q <= (irqs_q & ~((wrEn && pready && paddr == `UBR_OFF_IRQS) ?
        pwdata[`UBR_IRQ_W-1:0] : {`UBR_IRQ_W{1'b0}})) | evt;
      irq <= |(irqs_q & irqm_q);
      if (txStart) begin
        txPend_q <= 1'b0;
      end
      if (wrEn && pready) begin
        case (paddr)
          `UBR_OFF_CTRL: begin
            ctrl_q <= pwdata[5:0];
            // Bypass is one-way; only sys_rst clears it
            if (pwdata[`UBR_CTRL_BYPASS]) begin
              bypass_q <= 1'b1; // [RQ12] [RQ13]
            end
          end
          `UBR_OFF_DIV: begin
            // Clamp keeps rate at or below 4 Mbaud
            div_q <= (pwdata[15:0] < `UBR_DIV_MIN) ? `UBR_DIV_MIN : pwdata[15:0]; // [RQ1]
          end
          `UBR_OFF_TMO: tmo_q <= pwdata[`UBR_TMO_W-1:0];
          `UBR_OFF_TXD: begin
            txData_q <= pwdata[7:0];
            txPend_q <= 1'b1;
          end
          `UBR_OFF_IRQS: ;
          `UBR_OFF_IRQM: irqm_q <= pwdata[`UBR_IRQ_W-1:0];
          `UBR_OFF_RXD: ;
          `UBR_OFF_STAT: ;
          // Error already flagged in setup; must not outlive pready
          default: ;
        endcase
      end
      if (rdEn && pready) begin
        pready <= 1'b0;
      end
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `UBR_OFF_CTRL: prdata[5:0] <= {bypass_q, ctrl_q[4:0]};
          `UBR_OFF_DIV: prdata[15:0] <= div_q;
          `UBR_OFF_TMO: prdata[`UBR_TMO_W-1:0] <= tmoEff;
          `UBR_OFF_TXD: prdata[7:0] <= txData_q;
          `UBR_OFF_RXD: prdata[7:0] <= rxData_q;
          `UBR_OFF_STAT: prdata[4:0] <= {brkSeen_q, rxFull_q, txPend_q,
            (rxState_q != RX_IDLE), (txState_q != TX_IDLE)};
          `UBR_OFF_IRQS: prdata[`UBR_IRQ_W-1:0] <= irqs_q;
          `UBR_OFF_IRQM: prdata[`UBR_IRQ_W-1:0] <= irqm_q;
          default: pslverr <= 1'b0;
        endcase
        pslverr <= !(paddr <= `UBR_OFF_IRQM && paddr[1:0] == 2'b00);
      end
    end
  end

  // -----------------------------
  // Transmitter
  // -----------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txState_q <= TX_IDLE;
      txShift_q <= 11'h7FF;
      txLeft_q <= 4'h0;
    end else begin
      case (txState_q)
        TX_IDLE: begin
          if (txStart) begin
            // Stop bits pad the top; parity sits after the data
            txShift_q <= ctrl_q[`UBR_CTRL_PAR_EN] ? {1'b1, parity, txData_q, 1'b0} :
              {2'b11, txData_q, 1'b0}; // [RQ18]
            txLeft_q <= 4'h9 + {3'b000, ctrl_q[`UBR_CTRL_PAR_EN]} +
              {3'b000, ctrl_q[`UBR_CTRL_TWO_STOP]} + 4'h1; // [RQ1]
            txState_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (txTick) begin
            txShift_q <= {1'b1, txShift_q[10:1]};
            txLeft_q <= txLeft_q - 4'h1;
            if (txLeft_q == 4'h1) begin
              txState_q <= TX_IDLE;
            end
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  // -----------------------------
  // Receiver and break detector
  // -----------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxState_q <= RX_IDLE;
      rxShift_q <= 10'h000;
      rxLeft_q <= 4'h0;
      rxData_q <= 8'h00;
      rxFull_q <= 1'b0;
      usCnt_q <= 7'h00;
      brkUs_q <= {`UBR_TMO_W{1'b0}};
      brkSeen_q <= 1'b0;
      breakResetReq <= 1'b0;
    end else begin
      if (rdEn && pready && paddr == `UBR_OFF_RXD) begin
        rxFull_q <= 1'b0;
      end
      // Microsecond base restarts whenever the line goes high
      if (rxIn) begin
        usCnt_q <= 7'h00; // [RQ17]
        brkUs_q <= {`UBR_TMO_W{1'b0}};
        brkSeen_q <= 1'b0;
      end else if (usCnt_q == `UBR_US_CYC - 1) begin
        usCnt_q <= 7'h00;
        if (brkUs_q != `UBR_TMO_MAX_US + 18'd1) begin
          brkUs_q <= brkUs_q + 18'd1; // [RQ17]
        end
      end else begin
        usCnt_q <= usCnt_q + 7'h01;
      end
      // Sustained low beyond timeout asks for a chip reset
      breakResetReq <= (tmoEff != `UBR_TMO_RST) && (brkUs_q > tmoEff); // [RQ5] [RQ7] [RQ15]
      case (rxState_q)
        RX_IDLE: begin
          if (rxStart) begin
            rxLeft_q <= 4'hA + {3'b000, ctrl_q[`UBR_CTRL_PAR_EN]};
            rxState_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rxTick) begin
            rxShift_q <= {rxIn, rxShift_q[9:1]}; // [RQ18]
            rxLeft_q <= rxLeft_q - 4'h1;
            if (rxLeft_q == 4'h1) begin
              rxState_q <= RX_IDLE;
              // Low stop bit with rxShift_q[9:2] all zero (the data, or parity and data bits 7:1) marks a break, not a byte
              if (!rxIn && rxShift_q[9:2] == 8'h00) begin
                brkSeen_q <= 1'b1; // [RQ4]
              end else begin
                rxData_q <= ctrl_q[`UBR_CTRL_PAR_EN] ? rxShift_q[8:1] : rxShift_q[9:2];
                rxFull_q <= 1'b1;
              end
            end
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // -----------------------------
  // Event pulses for sticky status
  // -----------------------------
  always @* begin
    evt = {`UBR_IRQ_W{1'b0}};
    if (rxState_q == RX_SHIFT && rxTick && rxLeft_q == 4'h1) begin
      evt[`UBR_IRQ_BREAK] = !rxIn && rxShift_q[9:2] == 8'h00;
      evt[`UBR_IRQ_FRMERR] = !rxIn && rxShift_q[9:2] != 8'h00;
      evt[`UBR_IRQ_RXDONE] = rxIn;
      evt[`UBR_IRQ_PARERR] = rxIn && ctrl_q[`UBR_CTRL_PAR_EN] &&
        (rxPar != rxShift_q[9]);
    end
    evt[`UBR_IRQ_TXDONE] = (txState_q == TX_SHIFT) && txTick && (txLeft_q == 4'h1);
  end

  // -----------------------------
  // Pin drivers and bypass routing
  // -----------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Outputs released so other parties can share the bus
      txOut <= 1'b1;
      txOe <= 1'b0; // [RQ9]
      request_to_send_out_n <= 1'b1;
      rtsOe <= 1'b0; // [RQ9]
      rxPullDown <= 1'b1; // [RQ16]
      rtsPullUp <= 1'b1; // [RQ16]
      hostRxOut <= 1'b1;
      hostCtsOutN <= 1'b1;
      bypassTxOut <= 1'b1;
      bypassRtsOutN <= 1'b1;
      deepSleep <= 1'b0;
    end else begin
      rxPullDown <= 1'b0;
      rtsPullUp <= 1'b0;
      txOe <= !bypass_q;
      rtsOe <= !bypass_q;
      deepSleep <= bypass_q; // [RQ12]
      // Forced low line wakes a sleeping host
      txOut <= !ctrl_q[`UBR_CTRL_TXBRK] && txShift_q[0]; // [RQ8]
      // Ready while receive byte has room; CTS tie-low gives no flow
      request_to_send_out_n <= ctrl_q[`UBR_CTRL_FLOW] && rxFull_q; // [RQ2] [RQ3]
      hostRxOut <= bypass_q ? rxIn : 1'b1;
      hostCtsOutN <= bypass_q ? clear_to_send_in_n : 1'b1;
      bypassTxOut <= bypass_q ? hostTxIn : 1'b1; // [RQ12]
      bypassRtsOutN <= bypass_q ? hostRtsInN : 1'b1;
    end
  end
endmodule

/* sim/ubr_uart_sva.sv */
// Checker for the pins of the break-reset UART.
// Assumes one ref_clk domain; bound to ubr_uart below.
`timescale 1ns/1ps
module ubr_uart_sva (
  input wire ref_clk,
  input wire sys_rst,
  input wire rxIn,
  input wire txOe,
  input wire rtsOe,
  input wire request_to_send_out_n,
  input wire rxPullDown,
  input wire rtsPullUp,
  input wire hostRxOut,
  input wire hostCtsOutN,
  input wire bypassTxOut,
  input wire bypassRtsOutN,
  input wire deepSleep,
  input wire breakResetReq
);
  // ----------------------------------------
  // Helper and properties
  // ----------------------------------------
  // Low time of rxIn; saturates so a held line cannot wrap
  reg [17:0] lowCnt_q;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      lowCnt_q <= 18'h00000;
    else if (rxIn)
      lowCnt_q <= 18'h00000;
    else if (lowCnt_q != 18'h3FFFF)
      lowCnt_q <= lowCnt_q + 18'h00001;
  end
  // Reset states must hold whatever the shared bus does
  chk_oe_reset: assert property (@(posedge ref_clk)
    sys_rst |-> !txOe && !rtsOe) else $error("uart drives in reset");
  chk_pull_reset: assert property (@(posedge ref_clk)
    sys_rst |-> rxPullDown && rtsPullUp && request_to_send_out_n) else $error("no pull in reset");
  chk_pull_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> !rxPullDown && !rtsPullUp) else $error("pull left on");
  chk_drive_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) && !deepSleep |-> txOe && rtsOe) else $error("pins not driven");
  chk_host_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !deepSleep |-> hostRxOut && hostCtsOutN && bypassTxOut && bypassRtsOutN)
    else $error("bypass pins active");
  // Bypass parks the port until a physical reset
  chk_sleep_oe: assert property (@(posedge ref_clk) disable iff (sys_rst)
    deepSleep |-> !txOe) else $error("tx driven in bypass");
  chk_sleep_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
    deepSleep |=> deepSleep) else $error("bypass left");
  // A reset request needs a long unbroken low
  chk_brk_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(breakResetReq) |-> !$past(rxIn, 3) && !$past(rxIn, 4)) else $error("break not low");
  chk_brk_min: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(breakResetReq) |-> lowCnt_q >= 18'h186A0) else $error("break too short");
endmodule

bind ubr_uart ubr_uart_sva u_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .rxIn(rxIn), .txOe(txOe), .rtsOe(rtsOe),
  .request_to_send_out_n(request_to_send_out_n), .rxPullDown(rxPullDown),
  .rtsPullUp(rtsPullUp), .hostRxOut(hostRxOut), .hostCtsOutN(hostCtsOutN),
  .bypassTxOut(bypassTxOut), .bypassRtsOutN(bypassRtsOutN), .deepSleep(deepSleep),
  .breakResetReq(breakResetReq)
);

/* sim/ubr_host_model.sv */
// Host-side serial partner: sends frames, breaks, decodes frames.
// Assumes tasks are entered just after a rising ref_clk edge.
`timescale 1ns/1ps
module ubr_host_model (
  input wire ref_clk,
  input wire txOut,
  output reg rxLine,
  output reg ctsN
);
  // Idle line high; CTS low as a board without flow gating would tie it
  // Host never drives the device's tx line, leaving it to the device
  initial begin
    rxLine = 1'b1;
    ctsN = 1'b0;
  end
  // One frame, start low, data LSB first, one stop; cyc sets speed
  task sendByte(input [7:0] b, input integer cyc);
    integer i;
    reg [9:0] fr;
    begin
      fr = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        rxLine <= fr[i];
        repeat (cyc) @(posedge ref_clk);
      end
    end
  endtask
  // Flow gate seen by the device's transmitter
  task setCts(input v);
    begin
      ctsN <= v;
    end
  endtask
  // Break: line held low, no framing at all
  task holdLow(input integer n);
    begin
      rxLine <= 1'b0;
      repeat (n) @(posedge ref_clk);
      rxLine <= 1'b1;
    end
  endtask
  // Samples ten bits after the start bit at mid-bit
  task recvFrame(input integer cyc, output [9:0] bits);
    integer i;
    begin
      while (txOut !== 1'b0)
        @(posedge ref_clk);
      repeat (cyc / 2) @(posedge ref_clk);
      for (i = 0; i < 10; i = i + 1) begin
        repeat (cyc) @(posedge ref_clk);
        bits[i] = txOut;
      end
    end
  endtask
endmodule

/* sim/ubr_uart_tb.sv */
// Self-checking bench for the break-reset UART.
// Assumes ubr_consts.vh on the include path; DIV is set to 32 cycles.
`timescale 1ns/1ps
`include "ubr_consts.vh"
module ubr_uart_tb;
  reg ref_clk = 1'b0;
  reg sys_rst, psel, penable, pwrite, hostTxIn, hostRtsN;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg err;
  integer error_cnt, checks_done, cycles;
  wire [31:0] prdata;
  wire pready, pslverr, rxIn, ctsN, txOut, txOe, rtsN, rtsOe, pullD, pullU;
  wire hRx, hCts, bTx, bRts, deepSleep, brkReq, irq;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  ubr_uart u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxIn(rxIn), .clear_to_send_in_n(ctsN), .txOut(txOut),
    .txOe(txOe), .request_to_send_out_n(rtsN), .rtsOe(rtsOe), .rxPullDown(pullD),
    .rtsPullUp(pullU), .hostTxIn(hostTxIn), .hostRtsInN(hostRtsN), .hostRxOut(hRx),
    .hostCtsOutN(hCts), .bypassTxOut(bTx), .bypassRtsOutN(bRts), .deepSleep(deepSleep),
    .breakResetReq(brkReq), .irq(irq));
  ubr_host_model u_host (.ref_clk(ref_clk), .txOut(txOut), .rxLine(rxIn), .ctsN(ctsN));

  // Hang guard; the run needs about 103400 cycles, mostly the 1 ms break
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 130000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
        @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    begin
      chk("oe in reset", {txOe, rtsOe}, 2'b00);
      chk("pulls", {pullD, pullU, rtsN}, 3'b111);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("oe run", {txOe, hRx, hCts}, 3'b111);
      apb(1'b0, `UBR_OFF_CTRL, 32'h00000000);
      chk("ctrl", rd, `UBR_CTRL_RST);
      apb(1'b0, `UBR_OFF_DIV, 32'h00000000);
      chk("div", rd, `UBR_DIV_RST);
      apb(1'b0, `UBR_OFF_TMO, 32'h00000000);
      chk("tmo", rd, `UBR_TMO_RST);
      apb(1'b0, 12'h020, 32'h00000000);
      chk("unmapped", err, 1'b1);
      apb(1'b1, `UBR_OFF_DIV, 32'h00000020);
    end
  endtask
  task tmo1(input [31:0] w, input [31:0] e);
    begin
      apb(1'b1, `UBR_OFF_TMO, w);
      apb(1'b0, `UBR_OFF_TMO, 32'h00000000);
      chk("tmo clamp", rd, e);
    end
  endtask
  // Frame check for one CTRL setting; expected bits built here
  task txCase(input [31:0] ctrl, input [7:0] b);
    reg [9:0] bits;
    reg [9:0] exp;
    begin
      exp = ctrl[0] ? {1'b1, (ctrl[1] ? ~^b : ^b), b} : {2'b11, b};
      apb(1'b1, `UBR_OFF_CTRL, ctrl);
      fork
        u_host.recvFrame(32, bits);
        apb(1'b1, `UBR_OFF_TXD, {24'h000000, b});
      join
      chk("tx frame", bits, exp);
      repeat (80) @(posedge ref_clk);
    end
  endtask
  // CTS high holds the byte back until it drops
  task t_flow;
    reg [9:0] bits;
    begin
      apb(1'b1, `UBR_OFF_CTRL, 32'h00000008);
      chk("rts ready", rtsN, 1'b0);
      u_host.setCts(1'b1);
      fork
        u_host.recvFrame(32, bits);
        begin
          apb(1'b1, `UBR_OFF_TXD, 32'h0000005A);
          repeat (400) @(posedge ref_clk);
          chk("tx held", txOut, 1'b1);
          u_host.setCts(1'b0);
        end
      join
      chk("tx flow", bits, 10'h35A);
      repeat (80) @(posedge ref_clk);
    end
  endtask
  task t_rx;
    begin
      apb(1'b1, `UBR_OFF_CTRL, 32'h00000008);
      apb(1'b1, `UBR_OFF_IRQS, 32'h0000001F);
      u_host.sendByte(8'hA5, 32);
      repeat (20) @(posedge ref_clk);
      chk("irq masked", irq, 1'b0);
      chk("rts full", rtsN, 1'b1);
      apb(1'b0, `UBR_OFF_RXD, 32'h00000000);
      chk("rx data", rd[7:0], 8'hA5);
      apb(1'b1, `UBR_OFF_IRQM, 32'h00000001);
      repeat (2) @(posedge ref_clk);
      chk("irq set", irq, 1'b1);
      chk("rts free", rtsN, 1'b0);
      apb(1'b1, `UBR_OFF_IRQS, 32'h0000001F);
      repeat (2) @(posedge ref_clk);
      chk("irq clear", irq, 1'b0);
    end
  endtask
  // Long low with zero timeout: flagged, never a reset request
  task break_low_duration;
    begin
      u_host.holdLow(600);
      repeat (40) @(posedge ref_clk);
      chk("no reset", brkReq, 1'b0);
      apb(1'b0, `UBR_OFF_IRQS, 32'h00000000);
      chk("brk flag", rd[`UBR_IRQ_BREAK], 1'b1);
      apb(1'b1, `UBR_OFF_CTRL, 32'h00000010);
      repeat (64) @(posedge ref_clk);
      chk("tx brk", txOut, 1'b0);
      apb(1'b1, `UBR_OFF_CTRL, 32'h00000000);
      repeat (64) @(posedge ref_clk);
      chk("tx idle", txOut, 1'b1);
    end
  endtask
  // 1 ms timeout: request only once the low time strictly exceeds it
  task t_brkRst;
    begin
      apb(1'b1, `UBR_OFF_TMO, 32'h000003E8);
      fork
        u_host.holdLow(100130);
        begin
          repeat (100050) @(posedge ref_clk);
          chk("rst early", brkReq, 1'b0);
          repeat (70) @(posedge ref_clk);
          chk("rst late", brkReq, 1'b1);
        end
      join
      repeat (4) @(posedge ref_clk);
      chk("rst clear", brkReq, 1'b0);
    end
  endtask
  task t_byp;
    begin
      hostTxIn <= 1'b0;
      hostRtsN <= 1'b0;
      apb(1'b1, `UBR_OFF_CTRL, 32'h00000020); // port idle, no traffic in flight
      repeat (3) @(posedge ref_clk);
      chk("bypass", {deepSleep, txOe, bTx, bRts, hCts}, 5'b10000);
      apb(1'b1, `UBR_OFF_CTRL, 32'h00000000);
      chk("stay", deepSleep, 1'b1);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("oe reset", txOe, 1'b0);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("wake", deepSleep, 1'b0);
    end
  endtask

  initial begin
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    sys_rst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    hostTxIn = 1'b1;
    hostRtsN = 1'b1;
    // Late in time zero so every reset process sees the edge
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    $display("reset test done");
    tmo1(32'h000003E7, 32'h00000000);
    tmo1(32'h000003E8, 32'h000003E8);
    tmo1(32'h0003E419, 32'h0003E418);
    tmo1(32'h00000000, 32'h00000000);
    $display("timeout test done");
    txCase(32'h00000003, 8'h07);
    txCase(32'h00000001, 8'h07);
    txCase(32'h00000004, 8'hC8);
    $display("transmit test done");
    t_flow;
    $display("flow test done");
    t_rx;
    $display("receive test done");
    break_low_duration;
    $display("break test done");
    t_brkRst;
    $display("break reset test done");
    t_byp;
    $display("bypass test done");
    test_done;
  end
endmodule
